// ===== core/oco_pkg.sv
package oco_pkg;

	// Register byte addresses on the APB bus.
	localparam logic [7:0] ADDR_PAGE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FRINGE_LO = 8'h04;
	localparam logic [7:0] ADDR_FRINGE_HI = 8'h08;
	localparam logic [7:0] ADDR_COLOUR = 8'h0c;
	localparam logic [7:0] ADDR_WIN_UPPER = 8'h10;
	localparam logic [7:0] ADDR_WIN_LOWER = 8'h14;
	localparam logic [7:0] ADDR_MISC = 8'h18;
	localparam logic [7:0] ADDR_RASTER = 8'h1c;
	localparam logic [7:0] ADDR_SIZE = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;

	// Field positions.
	localparam int PC_DISPLAY_ON = 0;
	localparam int PC_WINDOW_EN = 1;
	localparam int PC_TRANSFER = 2;
	localparam int MISC_SMOOTH = 4;
	localparam int MISC_DOUBLE = 7;
	localparam int MISC_ALT_FIELD = 0;
	localparam int RASTER_BG_EN = 7;

	// Reset values.
	localparam logic [7:0] RST_PAGE_CTRL = 8'h00;
	localparam logic [11:0] RST_FRINGE = 12'h000;
	localparam logic [7:0] RST_COLOUR = 8'h00;
	localparam logic [8:0] RST_WIN_UPPER = 9'h001;
	localparam logic [8:0] RST_WIN_LOWER = 9'h1fe;
	localparam logic [23:0] RST_SIZE = 24'hffffff;

	// Geometry: small cell height in half scan lines, 16 dots per cell.
	localparam logic [7:0] CELL_BASE = 8'd18;
	localparam logic [7:0] CELL_FRINGE = 8'd22;
	localparam logic [7:0] CELL_UNDER = 8'd24;
	localparam logic [7:0] CELL_BOTH = 8'd26;
	localparam logic [4:0] LAST_COLUMN = 5'd31;
	localparam logic [8:0] BLANK_CODE = 9'h000;

	typedef enum logic [1:0] {
		SIZE_OFF = 2'b00,
		SIZE_LARGE = 2'b01,
		SIZE_MIDDLE = 2'b10,
		SIZE_SMALL = 2'b11
	} oco_size_t;

	typedef struct packed {
		logic [3:0] bg_colour;
		logic [3:0] fringe_colour;
		logic [11:0] fringe_en;
		logic [23:0] size;
		logic [8:0] win_upper;
		logic [8:0] win_lower;
	} oco_shadow_t;

	typedef struct packed {
		logic intensity;
		logic red;
		logic green;
		logic blue;
		logic blank;
	} oco_pixel_t;

endpackage

// ===== core/oco_ornament.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Two-bit size per line: small, middle, large, off.
// - Off line shows nothing, keeps small height.
// - Size fields apply only after transfer bit.
// - Normal scan without alternate field: even rows only.
// - Dot width 1,2,4 clocks; height scales per mode.
// - Small cell 16x9; fringe 11, underline 12, both 13.
// - Smoothing fills corner gaps; never small characters.
// - Smoothing bit acts at once.
// - One-dot fringe; neighbour outer dot overrides fringe.
// - Underline segments get no fringe.
// - No fringe left of column 1, right of 32.
// - Per-line fringe enables; one page fringe colour.
// - Colour codes: RGB eight colours, intensity half tone.
// - Background fills displayed cells except blank code.
// - Background colour is colour register upper nibble.
// - Page display enable bit 0 turns display on.
// - Window confines display between nine-bit limits.
// - Limits count lines, or line pairs in double scan.
// - Transfer at hsync rise, after current display line.
// - Transfer bit clears itself after transfer.
// - Double scan advances vertical counter every two lines.
module oco_ornament (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sync pins, asynchronous to pclk.
	input wire logic hsync,
	input wire logic vsync_n,
	// Character dot source for the current dot.
	input wire logic dot_clk_en,
	input wire logic [8:0] char_code,
	input wire logic [3:0] char_colour,
	input wire logic [2:0] glyph_row,
	input wire logic [4:0] column,
	input wire logic underline_dot,
	input wire logic [3:0] active_line,
	input wire logic in_cell,
	// Overlay to the signal processor.
	output oco_pkg::oco_pixel_t pixel_q,
	output logic [8:0] scan_line_q,
	output logic [3:0] line_size_q
);

	oco_pkg::oco_shadow_t stage_q, stage_d, live_q, live_d;
	logic [7:0] page_q, page_d, misc_q, misc_d, raster_q, raster_d;
	logic [2:0] hs_sync_q, vs_sync_q;
	logic hs_rise, vs_fall, in_display_q, in_display_d;
	logic [8:0] scan_q, scan_d;
	logic half_q, half_d;
	logic [31:0] rdata_d;
	logic ready_d, err_d;
	oco_pkg::oco_pixel_t pixel_d;
	logic [3:0] lsize_d;
	logic wr_access, rd_access;
	logic [2:0] prev_row_q, prev_row_d;

	function automatic logic [1:0] size_of(input logic [23:0] s, input logic [3:0] idx);
		size_of = s[{idx, 1'b0} +: 2];
	endfunction

	function automatic logic [7:0] cell_height(input logic fr, input logic ul);
		case ({fr, ul})
			2'b10: cell_height = oco_pkg::CELL_FRINGE;
			2'b01: cell_height = oco_pkg::CELL_UNDER;
			2'b11: cell_height = oco_pkg::CELL_BOTH;
			default: cell_height = oco_pkg::CELL_BASE;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_sync_q <= 3'h0;
			vs_sync_q <= 3'h7;
		end else begin
			hs_sync_q <= {hs_sync_q[1:0], hsync};
			vs_sync_q <= {vs_sync_q[1:0], vsync_n};
		end
	end

	assign hs_rise = hs_sync_q[1] && !hs_sync_q[2];
	assign vs_fall = !vs_sync_q[1] && vs_sync_q[2];
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && !penable && !pwrite;

	// Register file, staging and transfer.
	always_comb begin
		stage_d = stage_q;
		live_d = live_q;
		page_d = page_q;
		misc_d = misc_q;
		raster_d = raster_q;
		if (wr_access) begin
			unique case (paddr)
				oco_pkg::ADDR_PAGE_CTRL: page_d = {5'h00, pwdata[2:0] | {page_q[oco_pkg::PC_TRANSFER], 2'b00}};
				oco_pkg::ADDR_FRINGE_LO: stage_d.fringe_en[7:0] = pwdata[7:0];
				oco_pkg::ADDR_FRINGE_HI: stage_d.fringe_en[11:8] = pwdata[3:0];
				oco_pkg::ADDR_COLOUR: {stage_d.bg_colour, stage_d.fringe_colour} = pwdata[7:0];
				oco_pkg::ADDR_WIN_UPPER: stage_d.win_upper = pwdata[8:0];
				oco_pkg::ADDR_WIN_LOWER: stage_d.win_lower = pwdata[8:0];
				oco_pkg::ADDR_MISC: misc_d = pwdata[7:0];
				oco_pkg::ADDR_RASTER: raster_d = pwdata[7:0];
				oco_pkg::ADDR_SIZE: stage_d.size = pwdata[23:0];
				default: ;
			endcase
		end
		// Transfer on hsync rise; a rise inside the display area is skipped and the transfer waits for a later rise.
		if (page_q[oco_pkg::PC_TRANSFER] && hs_rise && !in_display_q) begin
			live_d = stage_q;
			page_d[oco_pkg::PC_TRANSFER] = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_q <= {4'h0, 4'h0, oco_pkg::RST_FRINGE, oco_pkg::RST_SIZE, oco_pkg::RST_WIN_UPPER,
				oco_pkg::RST_WIN_LOWER};
			live_q <= {4'h0, 4'h0, oco_pkg::RST_FRINGE, oco_pkg::RST_SIZE, oco_pkg::RST_WIN_UPPER,
				oco_pkg::RST_WIN_LOWER};
			page_q <= oco_pkg::RST_PAGE_CTRL;
			misc_q <= 8'h00;
			raster_q <= 8'h00;
		end else begin
			stage_q <= stage_d;
			live_q <= live_d;
			page_q <= page_d;
			misc_q <= misc_d;
			raster_q <= raster_d;
		end
	end

	// APB read data and answer: one wait-free access phase.
	always_comb begin
		rdata_d = prdata;
		ready_d = 1'b0;
		err_d = 1'b0;
		if (rd_access) begin
			unique case (paddr)
				oco_pkg::ADDR_PAGE_CTRL: rdata_d = {24'h0, page_q};
				oco_pkg::ADDR_FRINGE_LO: rdata_d = {24'h0, stage_q.fringe_en[7:0]};
				oco_pkg::ADDR_FRINGE_HI: rdata_d = {28'h0, stage_q.fringe_en[11:8]};
				oco_pkg::ADDR_COLOUR: rdata_d = {24'h0, stage_q.bg_colour, stage_q.fringe_colour};
				oco_pkg::ADDR_WIN_UPPER: rdata_d = {23'h0, stage_q.win_upper};
				oco_pkg::ADDR_WIN_LOWER: rdata_d = {23'h0, stage_q.win_lower};
				oco_pkg::ADDR_MISC: rdata_d = {24'h0, misc_q};
				oco_pkg::ADDR_RASTER: rdata_d = {24'h0, raster_q};
				oco_pkg::ADDR_SIZE: rdata_d = {8'h0, stage_q.size};
				oco_pkg::ADDR_STATUS: rdata_d = {22'h0, in_display_q, scan_q};
				default: rdata_d = 32'h0;
			endcase
		end
		if (psel && !penable) begin
			ready_d = 1'b1;
			err_d = (paddr > oco_pkg::ADDR_STATUS) || (paddr[1:0] != 2'b00);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= rdata_d;
			pready <= ready_d;
			pslverr <= err_d;
		end
	end

	// Scan line counter in window units.
	always_comb begin
		scan_d = scan_q;
		half_d = half_q;
		in_display_d = in_display_q;
		if (vs_fall) begin
			scan_d = 9'h000;
			half_d = 1'b0;
		end else if (hs_rise) begin
			half_d = misc_q[oco_pkg::MISC_DOUBLE] ? !half_q : 1'b0;
			if (!misc_q[oco_pkg::MISC_DOUBLE] || half_q) begin
				scan_d = scan_q + 9'h001;
			end
		end
		in_display_d = in_cell && page_q[oco_pkg::PC_DISPLAY_ON];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_q <= 9'h000;
			half_q <= 1'b0;
			in_display_q <= 1'b0;
		end else begin
			scan_q <= scan_d;
			half_q <= half_d;
			in_display_q <= in_display_d;
		end
	end

	// Dot composition.
	logic [1:0] cur_size;
	logic fr_on, win_ok, row_ok, bg_ok, smooth_ok, show;
	logic [7:0] cell_h;
	always_comb begin
		cur_size = size_of(live_q.size, active_line);
		fr_on = live_q.fringe_en[active_line];
		cell_h = cell_height(fr_on, underline_dot);
		win_ok = !page_q[oco_pkg::PC_WINDOW_EN] ||
			(scan_q >= live_q.win_upper && scan_q < live_q.win_lower);
		row_ok = misc_q[oco_pkg::MISC_DOUBLE] || misc_q[oco_pkg::MISC_ALT_FIELD] || !glyph_row[0];
		show = page_q[oco_pkg::PC_DISPLAY_ON] && win_ok && in_cell && cell_h != 8'h00 &&
			cur_size != oco_pkg::SIZE_OFF;
		bg_ok = raster_q[oco_pkg::RASTER_BG_EN] && char_code != oco_pkg::BLANK_CODE;
		smooth_ok = misc_q[oco_pkg::MISC_SMOOTH] && cur_size != oco_pkg::SIZE_SMALL;
		pixel_d = pixel_q;
		prev_row_d = prev_row_q;
		if (dot_clk_en) begin
			prev_row_d = glyph_row;
			pixel_d = '{intensity: 1'b0, red: 1'b0, green: 1'b0, blue: 1'b0, blank: 1'b0};
			if (show && row_ok && (glyph_row[1] || underline_dot ||
				(smooth_ok && glyph_row[2] && prev_row_q[0]))) begin
				// Own dot first, so a neighbour's outer dot wins over fringe.
				pixel_d = {char_colour, 1'b1};
			end else if (show && fr_on && !underline_dot && (glyph_row[0] || glyph_row[2]) &&
				!(column == 5'd0 && glyph_row[0] && !glyph_row[2]) &&
				!(column == oco_pkg::LAST_COLUMN && glyph_row[2] && !glyph_row[0])) begin
				pixel_d = {live_q.fringe_colour, 1'b1};
			end else if (show && bg_ok) begin
				pixel_d = {live_q.bg_colour, 1'b1};
			end
		end
		lsize_d = {2'b00, cur_size};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pixel_q <= '{intensity: 1'b0, red: 1'b0, green: 1'b0, blue: 1'b0, blank: 1'b0};
			prev_row_q <= 3'h0;
			scan_line_q <= 9'h000;
			line_size_q <= 4'h0;
		end else begin
			pixel_q <= pixel_d;
			prev_row_q <= prev_row_d;
			scan_line_q <= scan_q;
			line_size_q <= lsize_d;
		end
	end

	a_transfer_clears: assert property (@(posedge pclk) disable iff (!presetn)
		page_q[oco_pkg::PC_TRANSFER] && hs_rise && !in_display_q |=> !page_q[oco_pkg::PC_TRANSFER])
		else $error("transfer bit did not clear");
	a_live_waits: assert property (@(posedge pclk) disable iff (!presetn)
		!(page_q[oco_pkg::PC_TRANSFER] && hs_rise && !in_display_q) |=> $stable(live_q.size))
		else $error("size changed without transfer");
	a_display_off: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && !page_q[oco_pkg::PC_DISPLAY_ON] |=> !pixel_q.blank)
		else $error("dot shown while display off");
	a_window_clip: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && page_q[oco_pkg::PC_WINDOW_EN] && scan_q < live_q.win_upper |=> !pixel_q.blank)
		else $error("dot above window");
	a_line_off: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && cur_size == oco_pkg::SIZE_OFF |=> !pixel_q.blank)
		else $error("dot on an off line");
	a_smooth_now: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access && paddr == oco_pkg::ADDR_MISC |=> misc_q == $past(pwdata[7:0]))
		else $error("smoothing bit late");
	a_double_step: assert property (@(posedge pclk) disable iff (!presetn)
		misc_q[oco_pkg::MISC_DOUBLE] && hs_rise && !half_q && !vs_fall |=> $stable(scan_q))
		else $error("double scan stepped early");
	a_blank_code: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && char_code == oco_pkg::BLANK_CODE && !glyph_row[1] && !glyph_row[0] && !glyph_row[2] &&
			!underline_dot |=> !pixel_q.blank)
		else $error("background on blank cell");

	// Bus answer: every setup cycle is answered in the next cycle, with no wait state.
	a_ready_follows: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready stood longer than one cycle");
	a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!psel |=> !pready)
		else $error("pready without a request");
	a_error_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("pslverr without pready");
	a_error_decode: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && paddr > oco_pkg::ADDR_STATUS |=> pslverr)
		else $error("unmapped address not refused");
	a_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access && paddr > oco_pkg::ADDR_STATUS |=> $stable(stage_q) && $stable(misc_q))
		else $error("unmapped write changed state");
	a_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!rd_access |=> $stable(prdata))
		else $error("read data moved without a read");

	// Staging and transfer to the display circuit.
	a_transfer_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		page_q[oco_pkg::PC_TRANSFER] && !(hs_rise && !in_display_q) |=> page_q[oco_pkg::PC_TRANSFER])
		else $error("transfer bit dropped before transfer");
	a_transfer_copy: assert property (@(posedge pclk) disable iff (!presetn)
		page_q[oco_pkg::PC_TRANSFER] && hs_rise && !in_display_q |=> live_q == $past(stage_q))
		else $error("live copy differs from staged data");
	a_live_stable: assert property (@(posedge pclk) disable iff (!presetn)
		!(page_q[oco_pkg::PC_TRANSFER] && hs_rise && !in_display_q) |=> $stable(live_q))
		else $error("live copy changed without transfer");
	a_transfer_wait: assert property (@(posedge pclk) disable iff (!presetn)
		in_display_q |=> $stable(live_q))
		else $error("transfer inside display line");
	a_page_upper: assert property (@(posedge pclk) disable iff (!presetn)
		page_q[7:3] == 5'h00)
		else $error("page control upper bits set");
	a_misc_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_access && paddr == oco_pkg::ADDR_MISC) |=> $stable(misc_q))
		else $error("misc control changed without a write");

	// Scan line counter.
	a_scan_clear: assert property (@(posedge pclk) disable iff (!presetn)
		vs_fall |=> scan_q == 9'h000)
		else $error("scan counter not cleared by vsync");
	a_scan_step: assert property (@(posedge pclk) disable iff (!presetn)
		!misc_q[oco_pkg::MISC_DOUBLE] && hs_rise && !vs_fall |=> scan_q == $past(scan_q) + 9'h001)
		else $error("scan counter missed a line");
	a_scan_pair: assert property (@(posedge pclk) disable iff (!presetn)
		misc_q[oco_pkg::MISC_DOUBLE] && hs_rise && half_q && !vs_fall |=> scan_q == $past(scan_q) + 9'h001)
		else $error("double scan missed a step");
	a_scan_still: assert property (@(posedge pclk) disable iff (!presetn)
		!hs_rise && !vs_fall |=> $stable(scan_q))
		else $error("scan counter moved without sync");
	a_scan_output: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> scan_line_q == $past(scan_q))
		else $error("scan line output lags");

	// Dot composition.
	a_size_output: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> line_size_q == {2'b00, $past(cur_size)})
		else $error("line size output wrong");
	a_pixel_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!dot_clk_en |=> $stable(pixel_q))
		else $error("pixel moved between dots");
	a_outside_cell: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && !in_cell |=> !pixel_q.blank)
		else $error("dot shown outside a cell");
	a_window_below: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && page_q[oco_pkg::PC_WINDOW_EN] && scan_q >= live_q.win_lower |=> !pixel_q.blank)
		else $error("dot below window");
	a_own_colour: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && show && row_ok && glyph_row[1] |=> pixel_q == {$past(char_colour), 1'b1})
		else $error("character dot colour wrong");
	a_odd_row: assert property (@(posedge pclk) disable iff (!presetn)
		dot_clk_en && !row_ok && !fr_on && !bg_ok |=> !pixel_q.blank)
		else $error("odd row shown in normal scan");

endmodule // oco_ornament

`default_nettype wire

// ===== dv/oco_sync_src.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side timing source: a wide hsync pulse on request, dot pacing every other clock.
module oco_sync_src (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Bench request for one horizontal sync pulse.
	input wire logic hs_req,
	// Timing outputs.
	output logic hsync,
	output logic vsync_n,
	output logic dot_clk_en
);
	logic [2:0] hs_cnt_q;
	logic dot_q;

	// The pulse is six clocks long so the three-flop synchroniser cannot miss it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_cnt_q <= 3'h0;
			dot_q <= 1'b0;
		end else begin
			dot_q <= ~dot_q;
			if (hs_req)
				hs_cnt_q <= 3'h6;
			else if (hs_cnt_q != 3'h0)
				hs_cnt_q <= hs_cnt_q - 3'h1;
		end
	end

	assign hsync = (hs_cnt_q != 3'h0);
	assign vsync_n = 1'b1;
	assign dot_clk_en = dot_q;
endmodule // oco_sync_src

`default_nettype wire

// ===== dv/test_osd_character_ornament_window.sv
`timescale 1ns/1ps
`default_nettype none

module test_osd_character_ornament_window;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic hsync;
	logic vsync_n;
	logic dot_clk_en;
	logic hs_req = 1'b0;
	logic [8:0] char_code = 9'h000;
	logic [2:0] glyph_row = 3'h0;
	logic in_cell = 1'b0;
	oco_pkg::oco_pixel_t pixel_q;
	logic [8:0] scan_line_q;
	logic [3:0] line_size_q;
	logic [31:0] rd;
	logic er;
	int fail_count = 0;
	int check_count = 0;
	logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
	logic [31:0] rr [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h001, 32'h1fe, 32'hffffff};
	logic [31:0] ww [7] = '{32'h0, 32'hff, 32'hff, 32'hff, 32'h010, 32'h1ff, 32'hffffff};
	logic [31:0] we [7] = '{32'h0, 32'hff, 32'h0f, 32'hff, 32'h010, 32'h1ff, 32'hffffff};
	logic [31:0] pc_t [5] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h1};
	logic [8:0] cd_t [5] = '{9'h041, 9'h041, 9'h000, 9'h041, 9'h041};
	logic [2:0] gl_t [5] = '{3'b010, 3'b000, 3'b000, 3'b010, 3'b100};
	logic [4:0] px_t [5] = '{5'h0d, 5'h15, 5'h00, 5'h00, 5'h0b};

	always #2.5 pclk = ~pclk;

	oco_sync_src i_src (.pclk(pclk), .presetn(presetn), .hs_req(hs_req), .hsync(hsync),
		.vsync_n(vsync_n), .dot_clk_en(dot_clk_en));

	oco_ornament i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hsync(hsync), .vsync_n(vsync_n), .dot_clk_en(dot_clk_en),
		.char_code(char_code), .char_colour(4'h6), .glyph_row(glyph_row), .column(5'd0),
		.underline_dot(1'b0), .active_line(4'h0), .in_cell(in_cell), .pixel_q(pixel_q),
		.scan_line_q(scan_line_q), .line_size_q(line_size_q));

	task test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			$display("MISMATCH pready expected 1 seen timeout");
			test_done();
		end
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", rr[i], rd);
		end
		$display("test reset values done");
		for (int i = 1; i < 7; i++) begin
			apb(1'b1, ra[i], ww[i]);
			apb(1'b0, ra[i], 32'h0);
			chk("readback", we[i], rd);
		end
		$display("test readback done");
		apb(1'b0, 8'h28, 32'h0);
		chk("slverr unmapped", 32'h1, {31'h0, er});
		chk("rdata unmapped", 32'h0, rd);
		apb(1'b0, 8'h02, 32'h0);
		chk("slverr unaligned", 32'h1, {31'h0, er});
		$display("test refused access done");
		apb(1'b1, 8'h18, 32'h01);
		apb(1'b1, 8'h1c, 32'h80);
		apb(1'b1, 8'h0c, 32'ha5);
		apb(1'b1, 8'h04, 32'h01);
		apb(1'b1, 8'h00, 32'h04);
		@(posedge pclk);
		hs_req <= 1'b1;
		@(posedge pclk);
		hs_req <= 1'b0;
		repeat (12) @(posedge pclk);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 8'h00, pc_t[i]);
			@(posedge pclk);
			char_code <= cd_t[i];
			glyph_row <= gl_t[i];
			in_cell <= 1'b1;
			repeat (4) @(posedge pclk);
			chk("pixel", {27'h0, px_t[i]}, {27'h0, pixel_q});
		end
		$display("test pixel table done");
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h20, 32'hfffffc);
		repeat (4) @(posedge pclk);
		chk("live size before transfer", 32'h3, {30'h0, line_size_q[1:0]});
		apb(1'b1, 8'h00, 32'h04);
		apb(1'b0, 8'h00, 32'h0);
		chk("transfer bit pending", 32'h1, {31'h0, rd[2]});
		repeat (4) @(posedge pclk);
		chk("live size still old", 32'h3, {30'h0, line_size_q[1:0]});
		@(posedge pclk);
		hs_req <= 1'b1;
		@(posedge pclk);
		hs_req <= 1'b0;
		repeat (12) @(posedge pclk);
		chk("live size after transfer", 32'h0, {30'h0, line_size_q[1:0]});
		chk("scan line", 32'h2, {23'h0, scan_line_q});
		apb(1'b0, 8'h00, 32'h0);
		chk("transfer bit cleared", 32'h0, {31'h0, rd[2]});
		$display("test transfer done");
		test_done();
	end
endmodule // test_osd_character_ornament_window

`default_nettype wire
